// *** rtl/nfc_pkg.sv ***
// Constants, command codes and state types for the flash control block
package nfc_pkg;
	localparam int NFC_DATA_W = 16;
	localparam int NFC_NUM_BLOCKS = 4;
	localparam int NFC_BLOCK_WORDS = 8;
	// Command codes, low byte of the data word
	localparam logic [7:0] NFC_CMD_READ_ARRAY = 8'hf0;
	localparam logic [7:0] NFC_CMD_READ_STATUS = 8'h71;
	localparam logic [7:0] NFC_CMD_CLEAR_STATUS = 8'h52;
	localparam logic [7:0] NFC_CMD_PROG_SETUP = 8'h4a;
	localparam logic [7:0] NFC_CMD_ERASE_SETUP = 8'h2c;
	localparam logic [7:0] NFC_CMD_ERASE_CONFIRM = 8'hd5;
	localparam logic [7:0] NFC_CMD_SUSPEND = 8'hb3;
	localparam logic [7:0] NFC_CMD_RESUME = 8'hd6;
	localparam logic [7:0] NFC_CMD_LOCK = 8'h61;
	localparam logic [7:0] NFC_CMD_UNLOCK = 8'h62;
	localparam logic [7:0] NFC_CMD_CFG_SETUP = 8'h63;
	localparam logic [7:0] NFC_CMD_PWD_SET = 8'h91;
	localparam logic [7:0] NFC_CMD_PWD_UNLOCK = 8'h92;
	localparam logic [7:0] NFC_CMD_PWD_RELOCK = 8'h93;
	localparam logic [7:0] NFC_CMD_PWD_PROT = 8'h94;
	// Protection flags carried with the protect command
	localparam int NFC_PROT_WR_BIT = 8;
	localparam int NFC_PROT_RD_BIT = 9;
	// Status word bit positions
	localparam int NFC_ST_READY = 7;
	localparam int NFC_ST_ESUSP = 6;
	localparam int NFC_ST_EERR = 5;
	localparam int NFC_ST_PERR = 4;
	localparam int NFC_ST_SUPERR = 3;
	localparam int NFC_ST_PSUSP = 2;
	localparam int NFC_ST_LOCKERR = 1;
	localparam int NFC_ST_PWDERR = 0;
	// Read configuration fields
	localparam int NFC_CFG_SYNC_BIT = 0;
	localparam int NFC_CFG_LAT_LSB = 1;
	localparam int NFC_CFG_LAT_W = 3;
	localparam logic [15:0] NFC_CFG_RESET = 16'h0000;
	// Reset values, and the word returned for read-protected blocks
	localparam logic [15:0] NFC_ERASED_WORD = 16'hffff;
	localparam logic [15:0] NFC_RPROT_WORD = 16'h0000;
	localparam logic [15:0] NFC_PWD_RESET = 16'h0000;
	localparam logic NFC_LOCK_RESET = 1'b1;
	// Timing
	localparam int NFC_CLK_PERIOD_PS = 25000;
	localparam int NFC_PROG_TIME_NS = 10000;
	localparam int NFC_ERASE_TIME_US = 200;
	localparam int NFC_PROG_CYCLES = (NFC_PROG_TIME_NS * 1000 + NFC_CLK_PERIOD_PS - 1)
		/ NFC_CLK_PERIOD_PS;
	localparam int NFC_ERASE_CYCLES = (NFC_ERASE_TIME_US * 1000000 + NFC_CLK_PERIOD_PS - 1)
		/ NFC_CLK_PERIOD_PS;
	typedef enum {NFC_OP_IDLE, NFC_OP_PROG, NFC_OP_ERASE, NFC_OP_PSUSP, NFC_OP_ESUSP} nfc_op_t;
	typedef enum {NFC_PH_NONE, NFC_PH_PROG, NFC_PH_ERASE, NFC_PH_CFG, NFC_PH_PWD_SET,
		NFC_PH_PWD_UNLOCK} nfc_phase_t;
	typedef enum {NFC_RM_ARRAY, NFC_RM_STATUS} nfc_rmode_t;
endpackage

// *** rtl/nfc_block_guard.sv ***
// Per-block lock and password protection flags
`timescale 1ns/1ps
module nfc_block_guard
	import nfc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic pin_reset,
	input wire logic lock_set,
	input wire logic lock_clr,
	input wire logic prot_load,
	input wire logic prot_wr,
	input wire logic prot_rd,
	input wire logic pwd_unlocked,
	output logic locked,
	output logic wr_blocked,
	output logic rd_blocked
);
	logic lock_reg;
	logic wprot_reg;
	logic rprot_reg;

	// Lock state; pin reset relocks every block for safety
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lock_reg <= NFC_LOCK_RESET;
		end else if (pin_reset) begin
			lock_reg <= NFC_LOCK_RESET;
		end else if (lock_set) begin
			lock_reg <= 1'b1;
		end else if (lock_clr) begin
			lock_reg <= 1'b0;
		end
	end

	// Password protection choice survives pin reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wprot_reg <= 1'b0;
			rprot_reg <= 1'b0;
		end else if (prot_load) begin
			wprot_reg <= prot_wr;
			rprot_reg <= prot_rd;
		end
	end

	// Protection only bites while the password is not presented
	assign locked = lock_reg;
	assign wr_blocked = lock_reg | (wprot_reg & ~pwd_unlocked);
	assign rd_blocked = rprot_reg & ~pwd_unlocked;
endmodule

// *** rtl/nfc_top.sv ***
// Control logic of a 16-bit parallel NOR flash: reads, commands, automation
`timescale 1ns/1ps
module nfc_top
	import nfc_pkg::*;
#(
	parameter int NUM_BLOCKS = NFC_NUM_BLOCKS,
	parameter int BLOCK_WORDS = NFC_BLOCK_WORDS,
	parameter int PROG_CYCLES = NFC_PROG_CYCLES,
	parameter int ERASE_CYCLES = NFC_ERASE_CYCLES
)(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic rst_n_pin,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic adv_n,
	input wire logic burst_clk,
	input wire logic [$clog2(NUM_BLOCKS*BLOCK_WORDS)-1:0] addr,
	input wire logic [NFC_DATA_W-1:0] dq_in,
	output logic [NFC_DATA_W-1:0] dq_out,
	output logic dq_oe_n,
	output logic wait_out,
	output logic wait_oe_n,
	input wire logic supply_lockout_threshold
);
	localparam int WAW = $clog2(BLOCK_WORDS);
	localparam int AW = $clog2(NUM_BLOCKS*BLOCK_WORDS);
	localparam int NW = NUM_BLOCKS * BLOCK_WORDS;

	if (NUM_BLOCKS < 2 || (NUM_BLOCKS & (NUM_BLOCKS - 1)) != 0 || BLOCK_WORDS < 2 ||
		(BLOCK_WORDS & (BLOCK_WORDS - 1)) != 0) begin : g_bad_geom
		$error("block count and block size must be powers of two, at least 2");
	end
	if (PROG_CYCLES < 8 || PROG_CYCLES > 65535 || ERASE_CYCLES < 8 ||
		ERASE_CYCLES > 65535) begin : g_bad_time
		$error("operation cycle counts must lie in 8 to 65535");
	end

	logic [15:0] mem_reg [NW];
	logic wr_act, wr_act_reg, wr_end;
	logic [AW-1:0] wr_addr_reg;
	logic [15:0] wr_data_reg;
	logic [7:0] cmd;
	logic [AW-WAW-1:0] wr_blk, erase_blk_reg;
	nfc_op_t op_reg;
	nfc_phase_t phase_reg, phase_next;
	nfc_rmode_t rm_reg;
	logic [15:0] prog_cnt_reg, erase_cnt_reg, cfg_reg, pwd_reg, status_word, rd_word;
	logic [AW-1:0] op_addr_reg, burst_addr_reg, rd_addr;
	logic [15:0] op_data_reg;
	logic nest_reg, pwd_unlocked_reg, busy, sync_en;
	logic op_prog_req, op_erase_req, bad_seq, susp_req, resume_req, cfg_load;
	logic pwd_set_load, pwd_try, pwd_relock, rm_array_req, rm_status_req, clr_status;
	logic lock_cmd, unlock_cmd, prot_cmd;
	logic [NUM_BLOCKS-1:0] lock_set_vec, lock_clr_vec, prot_load_vec;
	logic [NUM_BLOCKS-1:0] guard_lock, guard_wblock, guard_rblock;
	logic wr_lock_hit, prog_conflict, prog_start, erase_start, prog_done, erase_done;
	logic err_supply_set, err_lock_set, err_prog_set, err_erase_set, err_pwd_set;
	logic err_supply_reg, err_lock_reg, err_prog_reg, err_erase_reg, err_pwd_reg;
	logic bclk_prev_reg, bclk_rise, burst_active_reg;
	logic [NFC_CFG_LAT_W-1:0] lat_cnt_reg;
	logic [15:0] dq_out_reg;

	// Writes end on whichever of strobe or select rises first
	assign wr_act = ~ce_n & ~we_n & rst_n_pin;
	assign wr_end = wr_act_reg & ~wr_act;
	assign cmd = wr_data_reg[7:0];
	assign wr_blk = wr_addr_reg[AW-1:WAW];
	assign busy = (op_reg == NFC_OP_PROG) || (op_reg == NFC_OP_ERASE);

	// Address and data follow the bus until the write ends
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_act_reg <= 1'b0;
			wr_addr_reg <= '0;
			wr_data_reg <= '0;
		end else begin
			wr_act_reg <= wr_act;
			if (wr_act) begin
				wr_addr_reg <= addr;
				wr_data_reg <= dq_in;
			end
		end
	end

	// Command decode, one strobe per completed write
	always_comb begin
		{op_prog_req, op_erase_req, bad_seq, susp_req, resume_req, cfg_load} = '0;
		{pwd_set_load, pwd_try, pwd_relock, rm_array_req, rm_status_req, clr_status} = '0;
		{lock_cmd, unlock_cmd, prot_cmd} = '0;
		phase_next = phase_reg;
		if (wr_end) begin
			phase_next = NFC_PH_NONE;
			case (phase_reg)
				NFC_PH_PROG: op_prog_req = 1'b1;
				NFC_PH_ERASE: begin
					op_erase_req = (cmd == NFC_CMD_ERASE_CONFIRM);
					bad_seq = (cmd != NFC_CMD_ERASE_CONFIRM);
				end
				NFC_PH_CFG: cfg_load = 1'b1;
				NFC_PH_PWD_SET: pwd_set_load = 1'b1;
				NFC_PH_PWD_UNLOCK: pwd_try = 1'b1;
				default: begin
					if (busy) begin
						// Only suspend and status polling during an operation
						susp_req = (cmd == NFC_CMD_SUSPEND);
						rm_status_req = (cmd == NFC_CMD_READ_STATUS);
					end else begin
						case (cmd)
							NFC_CMD_PROG_SETUP: begin
								if (op_reg != NFC_OP_PSUSP) begin
									phase_next = NFC_PH_PROG;
								end
							end
							NFC_CMD_ERASE_SETUP: begin
								if (op_reg == NFC_OP_IDLE) begin
									phase_next = NFC_PH_ERASE;
								end
							end
							NFC_CMD_CFG_SETUP: phase_next = NFC_PH_CFG;
							NFC_CMD_PWD_SET: phase_next = NFC_PH_PWD_SET;
							NFC_CMD_PWD_UNLOCK: phase_next = NFC_PH_PWD_UNLOCK;
							NFC_CMD_RESUME: resume_req = (op_reg != NFC_OP_IDLE);
							NFC_CMD_READ_ARRAY: rm_array_req = 1'b1;
							NFC_CMD_READ_STATUS: rm_status_req = 1'b1;
							NFC_CMD_CLEAR_STATUS: clr_status = 1'b1;
							NFC_CMD_LOCK: lock_cmd = 1'b1;
							NFC_CMD_UNLOCK: unlock_cmd = 1'b1;
							NFC_CMD_PWD_RELOCK: pwd_relock = 1'b1;
							NFC_CMD_PWD_PROT: prot_cmd = 1'b1;
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	// One-hot block strobes toward the guards
	always_comb begin
		lock_set_vec = '0;
		lock_clr_vec = '0;
		prot_load_vec = '0;
		lock_set_vec[wr_blk] = lock_cmd;
		lock_clr_vec[wr_blk] = unlock_cmd;
		prot_load_vec[wr_blk] = prot_cmd;
	end

	for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_guard
		nfc_block_guard u_guard (
			.ref_clk(ref_clk),
			.rst(rst),
			.pin_reset(~rst_n_pin),
			.lock_set(lock_set_vec[b]),
			.lock_clr(lock_clr_vec[b]),
			.prot_load(prot_load_vec[b]),
			.prot_wr(wr_data_reg[NFC_PROT_WR_BIT]),
			.prot_rd(wr_data_reg[NFC_PROT_RD_BIT]),
			.pwd_unlocked(pwd_unlocked_reg),
			.locked(guard_lock[b]),
			.wr_blocked(guard_wblock[b]),
			.rd_blocked(guard_rblock[b])
		);
	end

	// Admission checks; any failure leaves the array untouched
	assign wr_lock_hit = guard_wblock[wr_blk];
	assign prog_conflict = (op_reg == NFC_OP_ESUSP) && (wr_blk == erase_blk_reg);
	assign prog_start = op_prog_req & ~supply_lockout_threshold & ~wr_lock_hit &
		~prog_conflict;
	assign erase_start = op_erase_req & ~supply_lockout_threshold & ~wr_lock_hit;
	assign prog_done = (op_reg == NFC_OP_PROG) && (prog_cnt_reg == 16'h0001) &&
		!supply_lockout_threshold && rst_n_pin;
	assign erase_done = (op_reg == NFC_OP_ERASE) && (erase_cnt_reg == 16'h0001) &&
		!supply_lockout_threshold && rst_n_pin;
	assign err_supply_set = ((op_prog_req | op_erase_req | busy) &
		supply_lockout_threshold) | (pwd_set_load & ~pwd_unlocked_reg);
	assign err_lock_set = (op_prog_req | op_erase_req) & wr_lock_hit;
	assign err_prog_set = (op_prog_req & ~prog_start) |
		((op_reg == NFC_OP_PROG) & supply_lockout_threshold);
	assign err_erase_set = (op_erase_req & ~erase_start) | bad_seq |
		((op_reg == NFC_OP_ERASE) & supply_lockout_threshold);
	assign err_pwd_set = pwd_try & (wr_data_reg != pwd_reg);

	// Program and erase automation with suspend and nesting
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			op_reg <= NFC_OP_IDLE;
			prog_cnt_reg <= '0;
			erase_cnt_reg <= '0;
			op_addr_reg <= '0;
			op_data_reg <= '0;
			erase_blk_reg <= '0;
			nest_reg <= 1'b0;
		end else if (!rst_n_pin) begin
			op_reg <= NFC_OP_IDLE;
			nest_reg <= 1'b0;
		end else begin
			case (op_reg)
				NFC_OP_IDLE, NFC_OP_ESUSP: begin
					if (prog_start) begin
						op_reg <= NFC_OP_PROG;
						prog_cnt_reg <= 16'(PROG_CYCLES);
						op_addr_reg <= wr_addr_reg;
						op_data_reg <= wr_data_reg;
						nest_reg <= (op_reg == NFC_OP_ESUSP);
					end else if (op_reg == NFC_OP_ESUSP && resume_req) begin
						op_reg <= NFC_OP_ERASE;
					end else if (erase_start) begin
						op_reg <= NFC_OP_ERASE;
						erase_cnt_reg <= 16'(ERASE_CYCLES);
						erase_blk_reg <= wr_blk;
					end
				end
				NFC_OP_PROG: begin
					// Nested program cannot itself be suspended
					if (supply_lockout_threshold || prog_cnt_reg == 16'h0001) begin
						op_reg <= nest_reg ? NFC_OP_ESUSP : NFC_OP_IDLE;
						nest_reg <= 1'b0;
					end else if (susp_req && !nest_reg) begin
						op_reg <= NFC_OP_PSUSP;
					end else begin
						prog_cnt_reg <= prog_cnt_reg - 16'h0001;
					end
				end
				NFC_OP_ERASE: begin
					if (supply_lockout_threshold || erase_cnt_reg == 16'h0001) begin
						op_reg <= NFC_OP_IDLE;
					end else if (susp_req) begin
						op_reg <= NFC_OP_ESUSP;
					end else begin
						erase_cnt_reg <= erase_cnt_reg - 16'h0001;
					end
				end
				NFC_OP_PSUSP: begin
					if (resume_req) begin
						op_reg <= NFC_OP_PROG;
					end
				end
				default: op_reg <= NFC_OP_IDLE;
			endcase
		end
	end

	// Array storage; programming only clears bits
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NW; i++) begin
				mem_reg[i] <= NFC_ERASED_WORD;
			end
		end else if (prog_done) begin
			mem_reg[op_addr_reg] <= mem_reg[op_addr_reg] & op_data_reg;
		end else if (erase_done) begin
			for (int i = 0; i < NW; i++) begin
				if (i / BLOCK_WORDS == int'(erase_blk_reg)) begin
					mem_reg[i] <= NFC_ERASED_WORD;
				end
			end
		end
	end

	// Mode, configuration and password; pin reset returns to array read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_reg <= NFC_PH_NONE;
			rm_reg <= NFC_RM_ARRAY;
			cfg_reg <= NFC_CFG_RESET;
			pwd_reg <= NFC_PWD_RESET;
			pwd_unlocked_reg <= 1'b0;
		end else if (!rst_n_pin) begin
			phase_reg <= NFC_PH_NONE;
			rm_reg <= NFC_RM_ARRAY;
			cfg_reg <= NFC_CFG_RESET;
			pwd_unlocked_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			if (prog_start || erase_start || rm_status_req) begin
				rm_reg <= NFC_RM_STATUS;
			end else if (rm_array_req) begin
				rm_reg <= NFC_RM_ARRAY;
			end
			if (cfg_load) begin
				cfg_reg <= wr_data_reg;
			end
			// Password may only be replaced by whoever already knows it
			if (pwd_set_load && pwd_unlocked_reg) begin
				pwd_reg <= wr_data_reg;
			end
			if (pwd_try && wr_data_reg == pwd_reg) begin
				pwd_unlocked_reg <= 1'b1;
			end else if (pwd_relock) begin
				pwd_unlocked_reg <= 1'b0;
			end
		end
	end

	// Sticky error flags; a new error outranks a clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{err_supply_reg, err_lock_reg, err_prog_reg, err_erase_reg, err_pwd_reg} <= '0;
		end else if (!rst_n_pin) begin
			{err_supply_reg, err_lock_reg, err_prog_reg, err_erase_reg, err_pwd_reg} <= '0;
		end else begin
			err_supply_reg <= err_supply_set | (err_supply_reg & ~clr_status);
			err_lock_reg <= err_lock_set | (err_lock_reg & ~clr_status);
			err_prog_reg <= err_prog_set | (err_prog_reg & ~clr_status);
			err_erase_reg <= err_erase_set | (err_erase_reg & ~clr_status);
			err_pwd_reg <= err_pwd_set | (err_pwd_reg & ~clr_status);
		end
	end

	// Status word layout
	always_comb begin
		status_word = '0;
		status_word[NFC_ST_READY] = !busy;
		status_word[NFC_ST_ESUSP] = (op_reg == NFC_OP_ESUSP) || nest_reg;
		status_word[NFC_ST_EERR] = err_erase_reg;
		status_word[NFC_ST_PERR] = err_prog_reg;
		status_word[NFC_ST_SUPERR] = err_supply_reg;
		status_word[NFC_ST_PSUSP] = (op_reg == NFC_OP_PSUSP);
		status_word[NFC_ST_LOCKERR] = err_lock_reg;
		status_word[NFC_ST_PWDERR] = err_pwd_reg;
	end

	// Burst engine; burst clock is sampled, so it must stay well below ref_clk
	assign sync_en = cfg_reg[NFC_CFG_SYNC_BIT];
	assign bclk_rise = burst_clk & ~bclk_prev_reg;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bclk_prev_reg <= 1'b0;
			burst_active_reg <= 1'b0;
			burst_addr_reg <= '0;
			lat_cnt_reg <= '0;
		end else begin
			bclk_prev_reg <= burst_clk;
			if (ce_n || !rst_n_pin || !sync_en) begin
				burst_active_reg <= 1'b0;
			end else if (bclk_rise && !adv_n) begin
				burst_active_reg <= 1'b1;
				burst_addr_reg <= addr;
				lat_cnt_reg <= cfg_reg[NFC_CFG_LAT_LSB +: NFC_CFG_LAT_W];
			end else if (bclk_rise && burst_active_reg) begin
				if (lat_cnt_reg != '0) begin
					lat_cnt_reg <= lat_cnt_reg - 1'b1;
				end else begin
					burst_addr_reg <= burst_addr_reg + 1'b1;
				end
			end
		end
	end

	// Read data register: status, burst word or flow-through array word
	assign rd_addr = sync_en ? burst_addr_reg : addr;
	assign rd_word = guard_rblock[rd_addr[AW-1:WAW]] ? NFC_RPROT_WORD : mem_reg[rd_addr];
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dq_out_reg <= '0;
		end else begin
			dq_out_reg <= (rm_reg == NFC_RM_STATUS) ? status_word : rd_word;
		end
	end

	// Drivers float whenever the chip is not selected for a read
	assign dq_out = dq_out_reg;
	assign dq_oe_n = ~(~ce_n & ~oe_n & we_n & rst_n_pin);
	assign wait_oe_n = dq_oe_n;
	assign wait_out = sync_en & ~ce_n & (~burst_active_reg | (lat_cnt_reg != '0));

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_prog_go;
		(op_reg == NFC_OP_IDLE) && prog_start;
	endsequence
	sequence s_prog_quiet;
		(!supply_lockout_threshold && !susp_req && rst_n_pin) [*4];
	endsequence
	property p_reset_exit;
		!rst_n_pin |=> op_reg == NFC_OP_IDLE && rm_reg == NFC_RM_ARRAY && !sync_en;
	endproperty
	a_reset_exit: assert property (p_reset_exit) else $error("reset pin did not restore array read");
	property p_async_no_wait;
		!sync_en |-> !wait_out;
	endproperty
	a_async_no_wait: assert property (p_async_no_wait) else $error("wait raised in async mode");
	property p_hiz;
		ce_n |-> dq_oe_n && wait_oe_n;
	endproperty
	a_hiz: assert property (p_hiz) else $error("outputs driven while deselected");
	property p_wait;
		burst_active_reg && lat_cnt_reg != '0 && !ce_n |-> wait_out;
	endproperty
	a_wait: assert property (p_wait) else $error("wait low during latency");
	property p_burst_step;
		burst_active_reg && lat_cnt_reg == '0 && bclk_rise && !ce_n && adv_n && sync_en &&
			rst_n_pin |=> burst_addr_reg == $past(burst_addr_reg) + 1'b1;
	endproperty
	a_burst_step: assert property (p_burst_step) else $error("burst address did not step");
	property p_lockout;
		(op_prog_req || op_erase_req) && supply_lockout_threshold && rst_n_pin |=>
			op_reg == $past(op_reg) && err_supply_reg;
	endproperty
	a_lockout: assert property (p_lockout) else $error("operation started under lockout");
	property p_locked;
		op_prog_req && wr_lock_hit && op_reg == NFC_OP_IDLE && rst_n_pin |=>
			op_reg == NFC_OP_IDLE && err_lock_reg;
	endproperty
	a_locked: assert property (p_locked) else $error("locked block accepted program");
	property p_esusp;
		op_reg == NFC_OP_ERASE && susp_req && !supply_lockout_threshold && rst_n_pin
			&& erase_cnt_reg != 16'h0001 |=> (op_reg == NFC_OP_ESUSP) [*2];
	endproperty
	a_esusp: assert property (p_esusp) else $error("erase did not suspend");
	property p_prog_auto;
		s_prog_go ##1 s_prog_quiet |-> op_reg == NFC_OP_PROG && !status_word[NFC_ST_READY];
	endproperty
	a_prog_auto: assert property (p_prog_auto) else $error("program left automation early");
	property p_prog_done;
		prog_done && !nest_reg && rst_n_pin |=> op_reg == NFC_OP_IDLE &&
			status_word[NFC_ST_READY] && mem_reg[op_addr_reg] == ($past(mem_reg[op_addr_reg])
			& op_data_reg);
	endproperty
	a_prog_done: assert property (p_prog_done) else $error("program result wrong");
	property p_erase_one;
		erase_done && erase_blk_reg != '0 && rst_n_pin |=> $stable(mem_reg[0]);
	endproperty
	a_erase_one: assert property (p_erase_one) else $error("erase touched another block");
	property p_lock_now;
		(lock_clr_vec != '0) && rst_n_pin |=> (guard_lock & $past(lock_clr_vec)) == '0;
	endproperty
	a_lock_now: assert property (p_lock_now) else $error("unlock not immediate");
endmodule

// *** verif/nfc_host.sv ***
// Host-side bus model: write and read cycles on the flash pins
`timescale 1ns/1ps
module nfc_host
	import nfc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [NFC_DATA_W-1:0] dq_out,
	input wire logic wait_out,
	output logic adv_n,
	output logic burst_clk,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic [4:0] addr,
	output logic [NFC_DATA_W-1:0] dq_in
);
	// Idle bus, deselected
	initial begin
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		adv_n = 1'b1;
		burst_clk = 1'b0;
		addr = 5'h00;
		dq_in = 16'h0000;
	end

	// Burst read of two words; the host makes the clock and counts wait periods
	task automatic brd(input logic [4:0] a, output logic [15:0] q0, output logic [15:0] q1,
		output int nwait);
		int got;
		got = 0;
		nwait = 0;
		@(negedge ref_clk);
		addr = a;
		ce_n = 1'b0;
		oe_n = 1'b0;
		adv_n = 1'b0;
		@(negedge ref_clk);
		burst_clk = 1'b1;
		@(negedge ref_clk);
		adv_n = 1'b1;
		// Clock kept slow against ref_clk, since the block samples it
		for (int i = 0; i < 16 && got < 2; i++) begin
			repeat (2) @(negedge ref_clk);
			burst_clk = 1'b0;
			repeat (2) @(negedge ref_clk);
			// Data only taken once wait has dropped
			if (wait_out) begin
				nwait++;
			end else if (got == 0) begin
				q0 = dq_out;
				got = 1;
			end else begin
				q1 = dq_out;
				got = 2;
			end
			if (got < 2) begin
				burst_clk = 1'b1;
			end
		end
		if (got < 2) begin
			nwait = -1;
		end
		ce_n = 1'b1;
		oe_n = 1'b1;
	endtask

	// Address and data held past the strobe rise, then the bus is released
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		addr = a;
		dq_in = d;
		ce_n = 1'b0;
		we_n = 1'b0;
		@(negedge ref_clk);
		we_n = 1'b1;
		ce_n = 1'b1;
		@(negedge ref_clk);
		dq_in = ~d; // Inverse, so a late latch shows up
		@(negedge ref_clk);
	endtask

	// Data taken two edges after the address settles
	task automatic rd(input logic [4:0] a, output logic [15:0] q);
		@(negedge ref_clk);
		addr = a;
		ce_n = 1'b0;
		oe_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		q = dq_out;
		ce_n = 1'b1;
		oe_n = 1'b1;
	endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the flash control block
`timescale 1ns/1ps
module testbench
	import nfc_pkg::*;
;
	logic ref_clk, rst, rst_n_pin, adv_n, burst_clk, lockout, ce_n, oe_n, we_n;
	logic dq_oe_n, wait_out, wait_oe_n;
	logic [4:0] addr;
	logic [15:0] dq_in, dq_out, q, q1;
	int n_fail, checks_done, bw;

	// Short counts keep program and erase runs brief
	nfc_top #(.PROG_CYCLES(16), .ERASE_CYCLES(32)) i_nfc_top (
		.ref_clk(ref_clk), .rst(rst), .rst_n_pin(rst_n_pin), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .adv_n(adv_n), .burst_clk(burst_clk), .addr(addr), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .wait_out(wait_out), .wait_oe_n(wait_oe_n),
		.supply_lockout_threshold(lockout));
	nfc_host h (.ref_clk(ref_clk), .dq_out(dq_out), .wait_out(wait_out), .adv_n(adv_n),
		.burst_clk(burst_clk), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .addr(addr), .dq_in(dq_in));

	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [4:0] a, input logic [15:0] exp);
		h.rd(a, q);
		chk(q, exp);
	endtask

	// Poll status until ready, bounded, then compare the whole word
	task automatic st(input logic [15:0] exp);
		h.wr(5'h00, 16'h0071);
		for (int i = 0; i < 60; i++) begin
			h.rd(5'h00, q);
			if (q[NFC_ST_READY] === 1'b1) begin
				chk(q, exp);
				return;
			end
		end
		n_fail++;
		end_of_test();
	endtask

	task automatic end_of_test();
		$display("checks=%0d fails=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Main sequence; burst pins idle until the burst scenario
	initial begin
		rst = 1'b1;
		rst_n_pin = 1'b1;
		lockout = 1'b0;
		n_fail = 0;
		checks_done = 0;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		rc(5'h09, NFC_ERASED_WORD);
		#1;
		chk({14'h0000, dq_oe_n, wait_oe_n}, 16'h0003);
		chk({15'h0000, wait_out}, 16'h0000);
		// Blocks start locked: program refused with lock error
		h.wr(5'h09, 16'h004a);
		h.wr(5'h09, 16'h1234);
		st(16'h0092);
		h.wr(5'h00, 16'h0052);
		h.wr(5'h00, 16'h00f0);
		rc(5'h09, NFC_ERASED_WORD);
		// Unlock takes effect at once, program runs alone
		h.wr(5'h08, 16'h0062);
		h.wr(5'h09, 16'h004a);
		h.wr(5'h09, 16'h1234);
		st(16'h0080);
		h.wr(5'h00, 16'h00f0);
		rc(5'h09, 16'h1234);
		// Low supply refuses programming
		lockout = 1'b1;
		h.wr(5'h0a, 16'h004a);
		h.wr(5'h0a, 16'h0000);
		st(16'h0098);
		lockout = 1'b0;
		h.wr(5'h00, 16'h0052);
		h.wr(5'h00, 16'h00f0);
		rc(5'h0a, NFC_ERASED_WORD);
		// Erase of one block leaves the neighbour intact
		h.wr(5'h10, 16'h0062);
		h.wr(5'h10, 16'h004a);
		h.wr(5'h10, 16'h00ff);
		st(16'h0080);
		h.wr(5'h08, 16'h002c);
		h.wr(5'h08, 16'h00d5);
		st(16'h0080);
		h.wr(5'h00, 16'h00f0);
		rc(5'h09, NFC_ERASED_WORD);
		rc(5'h10, 16'h00ff);
		// Suspended erase allows reads in another block
		h.wr(5'h10, 16'h002c);
		h.wr(5'h10, 16'h00d5);
		h.wr(5'h00, 16'h00b3);
		st(16'h00c0);
		h.wr(5'h00, 16'h00f0);
		rc(5'h09, NFC_ERASED_WORD);
		h.wr(5'h00, 16'h00d6);
		st(16'h0080);
		// Program suspend lets another word in the same block be read
		h.wr(5'h11, 16'h004a);
		h.wr(5'h11, 16'h5a5a);
		h.wr(5'h00, 16'h00b3);
		st(16'h0084);
		h.wr(5'h00, 16'h00f0);
		rc(5'h10, NFC_ERASED_WORD);
		h.wr(5'h00, 16'h00d6);
		st(16'h0080);
		h.wr(5'h00, 16'h00f0);
		// Read protection until the password is presented, back after relock
		h.wr(5'h10, 16'h0294);
		rc(5'h11, NFC_RPROT_WORD);
		h.wr(5'h00, 16'h0092);
		h.wr(5'h00, NFC_PWD_RESET);
		rc(5'h11, 16'h5a5a);
		h.wr(5'h00, 16'h0093);
		rc(5'h11, NFC_RPROT_WORD);
		h.wr(5'h10, 16'h0094);
		// Burst with latency two; host counts the wait periods
		h.wr(5'h00, 16'h0063);
		h.wr(5'h00, 16'h0005);
		h.brd(5'h10, q, q1, bw);
		chk(q, NFC_ERASED_WORD);
		chk(q1, 16'h5a5a);
		chk(bw[15:0], 16'h0002);
		if (bw < 0) begin
			end_of_test();
		end
		// Lock command takes hold at once
		h.wr(5'h09, 16'h0061);
		h.wr(5'h09, 16'h004a);
		h.wr(5'h09, 16'h0000);
		st(16'h0092);
		// Pin reset returns to array read and relocks blocks
		rst_n_pin = 1'b0;
		repeat (3) @(negedge ref_clk);
		rst_n_pin = 1'b1;
		rc(5'h10, NFC_ERASED_WORD);
		h.wr(5'h10, 16'h004a);
		h.wr(5'h10, 16'h0000);
		st(16'h0092);
		end_of_test();
	end
endmodule
